// ==== design/ulc_pkg.sv ====
/*
 * Package for the serial line control registers: register indices, field positions,
 * reset values, mode encodings, carriers and timing counts.
 * Assumes a 20 MHz system clock; byte address of a register is four times its index.
 */
package ulc_pkg;
    localparam int CLK_PERIOD_NS     = 50;
    localparam int BREAK_TICK_NS     = 1000000;
    localparam int BREAK_TICK_CYCLES = BREAK_TICK_NS / CLK_PERIOD_NS;

    localparam logic [11:0] IDX_DRIVER_ACTIVE = 12'h20d;
    localparam logic [11:0] IDX_SH_PIN_FUNC   = 12'h217;
    localparam logic [11:0] IDX_SH_PIN_DIR    = 12'h218;
    localparam logic [11:0] IDX_SH_PIN_MASK   = 12'h219;
    localparam logic [11:0] IDX_PATH_ENABLE   = 12'hc00;
    localparam logic [11:0] IDX_FLOW_MODE     = 12'hc06;
    localparam logic [11:0] IDX_RESUME_CHAR   = 12'hc07;
    localparam logic [11:0] IDX_PAUSE_CHAR    = 12'hc08;
    localparam logic [11:0] IDX_LINE_ERR      = 12'hc09;
    localparam logic [11:0] IDX_BREAK_COUNT   = 12'hc0a;
    localparam logic [11:0] IDX_TURN_DELAY    = 12'hc0b;
    localparam logic [11:0] IDX_PIN_FUNC      = 12'hc0c;
    localparam logic [11:0] IDX_PIN_DIR       = 12'hc0d;
    localparam logic [11:0] IDX_PIN_MASK      = 12'hc11;
    localparam logic [11:0] IDX_WIDE_MODE     = 12'hd02;

    localparam int EN_TX_BIT      = 0;
    localparam int EN_RX_BIT      = 1;
    localparam int FLOW_HD_BIT    = 3;
    localparam int PF_POL_BIT     = 3;
    localparam int ERR_BRK_BIT    = 3;
    localparam int ERR_FRM_BIT    = 4;
    localparam int ERR_PAR_BIT    = 5;
    localparam int ERR_OVR_BIT    = 6;
    localparam int ERR_LIVE_BIT   = 7;
    localparam int DRV_ACTIVE_BIT = 0;
    localparam int WIDE_EN_BIT    = 0;

    localparam logic [7:0]  RESUME_RST = 8'h17;
    localparam logic [7:0]  PAUSE_RST  = 8'h19;
    localparam logic [11:0] BREAK_HOLD = 12'hfff;

    localparam logic [11:0] MASK_ENABLE = 12'h003;
    localparam logic [11:0] MASK_FLOW   = 12'h00f;
    localparam logic [11:0] MASK_CHAR   = 12'h0ff;
    localparam logic [11:0] MASK_ERR    = 12'h0f8;
    localparam logic [11:0] MASK_DELAY  = 12'h00f;
    localparam logic [11:0] MASK_PINS   = 12'h03f;
    localparam logic [11:0] MASK_BIT0   = 12'h001;

    localparam logic [1:0] OTP_SEL_FUNC = 2'h0;
    localparam logic [1:0] OTP_SEL_DIR  = 2'h1;
    localparam logic [1:0] OTP_SEL_MASK = 2'h2;

    typedef enum logic [2:0] {
        FM_NONE      = 3'h0,
        FM_HW        = 3'h1,
        FM_SW        = 3'h2,
        FM_MATCH_RX  = 3'h3,
        FM_MATCH_ALL = 3'h4
    } ulc_flow_mode_t;

    typedef enum logic [2:0] {
        PF_GPIO       = 3'h0,
        PF_RTS_CTS    = 3'h1,
        PF_DTR_DSR    = 3'h2,
        PF_XCVR_TX    = 3'h3,
        PF_XCVR_MATCH = 3'h4
    } ulc_pin_func_t;

    typedef enum logic [1:0] {
        XS_IDLE = 2'h0,
        XS_TX   = 2'h1,
        XS_HOLD = 2'h2
    } ulc_xcvr_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       frame_err;
        logic       parity_err;
        logic       break_err;
    } ulc_rx_evt_t;

    typedef struct packed {
        logic        we;
        logic [1:0]  sel;
        logic [11:0] data;
    } ulc_otp_wr_t;
endpackage

// ==== design/ulc_line_ctrl.sv ====
/*
 * Serial line control and status registers behind an APB slave: path enables, flow mode,
 * pause/resume characters, read-clear line errors, break countdown, transceiver turn-around,
 * and one-time-programmable shadows of the pin settings copied in on a class command.
 * Assumes the receiver, transmitter, FIFOs and baud generator sit outside and are synchronous to clk.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module ulc_line_ctrl #(
    parameter int MS_CYCLES = ulc_pkg::BREAK_TICK_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [15:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire ulc_pkg::ulc_otp_wr_t   otp_wr,
    input  wire logic                   class_cmd,
    input  wire ulc_pkg::ulc_rx_evt_t   rx_evt,
    input  wire logic                   rx_fifo_full,
    input  wire logic                   break_live,
    input  wire logic                   addr_match,
    input  wire logic                   tx_busy,
    input  wire logic                   bit_tick,
    input  wire logic                   clear_to_send,
    input  wire logic                   set_ready,
    output logic                        tx_enable,
    output logic                        rx_enable,
    output logic                        tx_allowed,
    output logic                        rx_accept,
    output ulc_pkg::ulc_flow_mode_t     flow_mode,
    output logic                        wide_mode,
    output logic                        line_break,
    output logic      [11:0]            pin_function,
    output logic      [5:0]             pin_direction,
    output logic      [5:0]             pin_irq_mask,
    output logic                        pin_five_o,
    output logic                        pin_five_oe
);
    if (MS_CYCLES < 2 || MS_CYCLES > 65536) begin : g_bad_ms
        $error("MS_CYCLES must lie between 2 and 65536");
    end

    function automatic logic mapped(input logic [11:0] idx);
        case (idx)
            ulc_pkg::IDX_DRIVER_ACTIVE, ulc_pkg::IDX_SH_PIN_FUNC, ulc_pkg::IDX_SH_PIN_DIR,
            ulc_pkg::IDX_SH_PIN_MASK, ulc_pkg::IDX_PATH_ENABLE, ulc_pkg::IDX_FLOW_MODE,
            ulc_pkg::IDX_RESUME_CHAR, ulc_pkg::IDX_PAUSE_CHAR, ulc_pkg::IDX_LINE_ERR,
            ulc_pkg::IDX_BREAK_COUNT, ulc_pkg::IDX_TURN_DELAY, ulc_pkg::IDX_PIN_FUNC,
            ulc_pkg::IDX_PIN_DIR, ulc_pkg::IDX_PIN_MASK, ulc_pkg::IDX_WIDE_MODE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    logic [11:0] drv_active_reg, sh_func_reg, sh_dir_reg, sh_mask_reg, enable_reg, flow_reg;
    logic [11:0] resume_reg, pause_reg, err_reg, err_next, break_cnt_reg, delay_reg;
    logic [11:0] func_reg, dir_reg, mask_reg, wide_reg, rd_val, err_set, err_clr, err_base;
    logic [31:0] prdata_reg;
    logic [15:0] ms_cnt_reg;
    logic [3:0]  turn_cnt_reg;
    logic        paused_reg, line_break_reg, ms_tick, addr_ok, setup, access, hw_ok, half_duplex_w;
    logic [11:0] idx;
    ulc_pkg::ulc_xcvr_state_t xs_reg;

    assign idx     = paddr[13:2];
    assign addr_ok = mapped(idx) && paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0;
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = access && !addr_ok;
    assign prdata  = prdata_reg;

    function automatic logic wr_hit(input logic [11:0] target, input logic acc, input logic wr,
                                    input logic ok, input logic [11:0] ix);
        wr_hit = acc && wr && ok && ix == target;
    endfunction

    always_comb begin
        case (idx)
            ulc_pkg::IDX_DRIVER_ACTIVE: rd_val = drv_active_reg;
            ulc_pkg::IDX_SH_PIN_FUNC:   rd_val = sh_func_reg;
            ulc_pkg::IDX_SH_PIN_DIR:    rd_val = sh_dir_reg;
            ulc_pkg::IDX_SH_PIN_MASK:   rd_val = sh_mask_reg;
            ulc_pkg::IDX_PATH_ENABLE:   rd_val = enable_reg;
            ulc_pkg::IDX_FLOW_MODE:     rd_val = flow_reg;
            ulc_pkg::IDX_RESUME_CHAR:   rd_val = resume_reg;
            ulc_pkg::IDX_PAUSE_CHAR:    rd_val = pause_reg;
            ulc_pkg::IDX_LINE_ERR:      rd_val = err_reg | {4'h0, break_live, 7'h00};
            ulc_pkg::IDX_BREAK_COUNT:   rd_val = break_cnt_reg;
            ulc_pkg::IDX_TURN_DELAY:    rd_val = delay_reg;
            ulc_pkg::IDX_PIN_FUNC:      rd_val = func_reg;
            ulc_pkg::IDX_PIN_DIR:       rd_val = dir_reg;
            ulc_pkg::IDX_PIN_MASK:      rd_val = mask_reg;
            ulc_pkg::IDX_WIDE_MODE:     rd_val = wide_reg;
            default:                    rd_val = 12'h000;
        endcase
    end

    // Read data is captured in the setup cycle so it comes from a flip-flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_reg <= {20'h00000, rd_val};
        end
    end

    // Plain software registers; writes mask off reserved bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv_active_reg <= 12'h000;
            enable_reg     <= 12'h000;
            flow_reg       <= 12'h000;
            resume_reg     <= {4'h0, ulc_pkg::RESUME_RST};
            pause_reg      <= {4'h0, ulc_pkg::PAUSE_RST};
            delay_reg      <= 12'h000;
            wide_reg       <= 12'h000;
        end else begin
            if (wr_hit(ulc_pkg::IDX_DRIVER_ACTIVE, access, pwrite, addr_ok, idx))
                drv_active_reg <= pwdata[11:0] & ulc_pkg::MASK_BIT0;
            if (wr_hit(ulc_pkg::IDX_PATH_ENABLE, access, pwrite, addr_ok, idx))
                enable_reg <= pwdata[11:0] & ulc_pkg::MASK_ENABLE;
            if (wr_hit(ulc_pkg::IDX_FLOW_MODE, access, pwrite, addr_ok, idx))
                flow_reg <= pwdata[11:0] & ulc_pkg::MASK_FLOW;
            if (wr_hit(ulc_pkg::IDX_RESUME_CHAR, access, pwrite, addr_ok, idx))
                resume_reg <= pwdata[11:0] & ulc_pkg::MASK_CHAR;
            if (wr_hit(ulc_pkg::IDX_PAUSE_CHAR, access, pwrite, addr_ok, idx))
                pause_reg <= pwdata[11:0] & ulc_pkg::MASK_CHAR;
            if (wr_hit(ulc_pkg::IDX_TURN_DELAY, access, pwrite, addr_ok, idx))
                delay_reg <= pwdata[11:0] & ulc_pkg::MASK_DELAY;
            if (wr_hit(ulc_pkg::IDX_WIDE_MODE, access, pwrite, addr_ok, idx))
                wide_reg <= pwdata[11:0] & ulc_pkg::MASK_BIT0;
        end
    end

    // Shadows: only the programmable store writes them; bus writes are dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_func_reg <= 12'h000;
            sh_dir_reg  <= 12'h000;
            sh_mask_reg <= 12'h000;
        end else if (otp_wr.we) begin
            if (otp_wr.sel == ulc_pkg::OTP_SEL_FUNC) sh_func_reg <= otp_wr.data & ulc_pkg::MASK_FLOW;
            if (otp_wr.sel == ulc_pkg::OTP_SEL_DIR)  sh_dir_reg  <= otp_wr.data & ulc_pkg::MASK_PINS;
            if (otp_wr.sel == ulc_pkg::OTP_SEL_MASK) sh_mask_reg <= otp_wr.data & ulc_pkg::MASK_PINS;
        end
    end

    // Live pin settings; a class command with no custom driver overrides a bus write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            func_reg <= 12'h000;
            dir_reg  <= 12'h000;
            mask_reg <= 12'h000;
        end else if (class_cmd && !drv_active_reg[ulc_pkg::DRV_ACTIVE_BIT]) begin
            func_reg <= sh_func_reg;
            dir_reg  <= sh_dir_reg;
            mask_reg <= sh_mask_reg;
        end else begin
            if (wr_hit(ulc_pkg::IDX_PIN_FUNC, access, pwrite, addr_ok, idx))
                func_reg <= pwdata[11:0] & ulc_pkg::MASK_FLOW;
            if (wr_hit(ulc_pkg::IDX_PIN_DIR, access, pwrite, addr_ok, idx))
                dir_reg <= pwdata[11:0] & ulc_pkg::MASK_PINS;
            if (wr_hit(ulc_pkg::IDX_PIN_MASK, access, pwrite, addr_ok, idx))
                mask_reg <= pwdata[11:0] & ulc_pkg::MASK_PINS;
        end
    end

    // Line error flags: the read clears only what it returned, new events win
    always_comb begin
        err_set = 12'h000;
        err_set[ulc_pkg::ERR_BRK_BIT] = break_live || (rx_evt.valid && rx_evt.break_err);
        err_set[ulc_pkg::ERR_FRM_BIT] = rx_evt.valid && rx_evt.frame_err;
        err_set[ulc_pkg::ERR_PAR_BIT] = rx_evt.valid && rx_evt.parity_err;
        err_set[ulc_pkg::ERR_OVR_BIT] = rx_evt.valid && rx_fifo_full;
        err_clr  = wr_hit(ulc_pkg::IDX_LINE_ERR, access, 1'b1, addr_ok, idx) && !pwrite ?
                   prdata_reg[11:0] : 12'h000;
        err_base = (wide_reg[ulc_pkg::WIDE_EN_BIT] && rx_evt.valid) ? 12'h000 : err_reg;
        err_next = ((err_base & ~err_clr) | err_set) & ulc_pkg::MASK_ERR & 12'h07f;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_reg <= 12'h000;
        end else begin
            err_reg <= err_next;
        end
    end

    // Millisecond enable for the break countdown
    assign ms_tick = ms_cnt_reg == 16'(MS_CYCLES - 1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_cnt_reg <= 16'h0000;
        end else begin
            ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            break_cnt_reg <= 12'h000;
        end else if (wr_hit(ulc_pkg::IDX_BREAK_COUNT, access, pwrite, addr_ok, idx)) begin
            break_cnt_reg <= pwdata[11:0];
        end else if (ms_tick && break_cnt_reg != 12'h000 && break_cnt_reg != ulc_pkg::BREAK_HOLD) begin
            break_cnt_reg <= break_cnt_reg - 12'h001;
        end
    end

    // Break starts only once the shifter is idle and ends at a zero count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_break_reg <= 1'b0;
        end else if (break_cnt_reg == 12'h000) begin
            line_break_reg <= 1'b0;
        end else if (!tx_busy) begin
            line_break_reg <= 1'b1;
        end
    end

    // Software flow: pause and resume characters seen on accepted bytes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            paused_reg <= 1'b0;
        end else if (flow_mode != ulc_pkg::FM_SW) begin
            paused_reg <= 1'b0;
        end else if (rx_evt.valid && rx_accept) begin
            if (rx_evt.data == pause_reg[7:0])
                paused_reg <= 1'b1;
            else if (rx_evt.data == resume_reg[7:0])
                paused_reg <= 1'b0;
        end
    end

    // Transceiver turn-around: hold the enable for a programmed number of bit times
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xs_reg       <= ulc_pkg::XS_IDLE;
            turn_cnt_reg <= 4'h0;
        end else begin
            case (xs_reg)
                ulc_pkg::XS_IDLE: begin
                    if (tx_busy) xs_reg <= ulc_pkg::XS_TX;
                end
                ulc_pkg::XS_TX: begin
                    if (!tx_busy) begin
                        turn_cnt_reg <= delay_reg[3:0];
                        xs_reg <= (delay_reg[3:0] == 4'h0) ? ulc_pkg::XS_IDLE : ulc_pkg::XS_HOLD;
                    end
                end
                ulc_pkg::XS_HOLD: begin
                    if (tx_busy) begin
                        xs_reg <= ulc_pkg::XS_TX;
                    end else if (bit_tick) begin
                        turn_cnt_reg <= turn_cnt_reg - 4'h1;
                        if (turn_cnt_reg == 4'h1) xs_reg <= ulc_pkg::XS_IDLE;
                    end
                end
                default: xs_reg <= ulc_pkg::XS_IDLE;
            endcase
        end
    end

    logic xcvr_active, xcvr_fn;
    assign xcvr_fn     = func_reg[2:0] == ulc_pkg::PF_XCVR_TX || func_reg[2:0] == ulc_pkg::PF_XCVR_MATCH;
    assign xcvr_active = (xs_reg != ulc_pkg::XS_IDLE || tx_busy) &&
                         (func_reg[2:0] != ulc_pkg::PF_XCVR_MATCH || addr_match);
    assign pin_five_oe = xcvr_fn;
    assign pin_five_o  = xcvr_fn && (xcvr_active == func_reg[ulc_pkg::PF_POL_BIT]);

    assign hw_ok = func_reg[2:0] == ulc_pkg::PF_DTR_DSR ? set_ready : clear_to_send;

    assign flow_mode     = ulc_pkg::ulc_flow_mode_t'(flow_reg[2:0]);
    assign tx_enable     = enable_reg[ulc_pkg::EN_TX_BIT];
    assign rx_enable     = enable_reg[ulc_pkg::EN_RX_BIT];
    assign half_duplex_w = flow_reg[ulc_pkg::FLOW_HD_BIT];
    assign tx_allowed    = tx_enable && !line_break_reg && !paused_reg &&
                           (flow_mode != ulc_pkg::FM_HW || hw_ok) &&
                           (flow_mode != ulc_pkg::FM_MATCH_ALL || addr_match);
    assign rx_accept     = rx_enable && !(half_duplex_w && tx_busy) &&
                           ((flow_mode != ulc_pkg::FM_MATCH_RX && flow_mode != ulc_pkg::FM_MATCH_ALL)
                            || addr_match);
    assign wide_mode     = wide_reg[ulc_pkg::WIDE_EN_BIT];
    assign line_break    = line_break_reg;
    assign pin_function  = func_reg;
    assign pin_direction = dir_reg[5:0];
    assign pin_irq_mask  = mask_reg[5:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_err_read;
        access && !pwrite && addr_ok && idx == ulc_pkg::IDX_LINE_ERR;
    endsequence
    sequence s_cmd_copy;
        class_cmd && !drv_active_reg[ulc_pkg::DRV_ACTIVE_BIT];
    endsequence

    a_shadow_copy: assert property (s_cmd_copy |=> func_reg == $past(sh_func_reg)
        && dir_reg == $past(sh_dir_reg) && mask_reg == $past(sh_mask_reg)) else $error("shadow copy missed");
    a_custom_ignore: assert property (class_cmd && drv_active_reg[0] && !access |=>
        $stable(func_reg)) else $error("shadow copied under custom driver");
    a_half_duplex: assert property (flow_reg[3] && tx_busy |-> !rx_accept) else $error("rx during tx");
    a_overrun_set: assert property (rx_evt.valid && rx_fifo_full ##0 s_err_read |=>
        err_reg[ulc_pkg::ERR_OVR_BIT]) else $error("overrun lost on read");
    a_read_clears: assert property (s_err_read ##0 (prdata_reg[4] && !rx_evt.valid) |=>
        !err_reg[ulc_pkg::ERR_FRM_BIT]) else $error("framing flag not cleared");
    a_live_break: assert property (setup && !pwrite && idx == ulc_pkg::IDX_LINE_ERR |=>
        prdata[7] == $past(break_live)) else $error("live break wrong");
    a_break_hold: assert property (break_cnt_reg == ulc_pkg::BREAK_HOLD && !access |=>
        break_cnt_reg == ulc_pkg::BREAK_HOLD) else $error("hold value decremented");
    a_break_dec: assert property (ms_tick && break_cnt_reg != 12'h000 && break_cnt_reg != 12'hfff
        && !access |=> break_cnt_reg == $past(break_cnt_reg) - 12'h001) else $error("no decrement");
    a_break_end: assert property (break_cnt_reg == 12'h000 |=> !line_break) else $error("break stuck");
    a_break_wait: assert property (!line_break && tx_busy |=> !line_break) else $error("break cut char");
    a_pause_char: assert property (flow_mode == ulc_pkg::FM_SW && rx_evt.valid && rx_accept &&
        rx_evt.data == pause_reg[7:0] |=> !tx_allowed) else $error("pause ignored");
    a_turn_hold: assert property (xs_reg == ulc_pkg::XS_TX && !tx_busy && delay_reg[3:0] != 4'h0
        |=> xs_reg == ulc_pkg::XS_HOLD) else $error("turn-around skipped");
endmodule

// ==== testbench/ulc_far_end.sv ====
/* Far-end serial partner model: received bytes, live break, transmitter busy, bit ticks.
   Assumes the bench clock; the bench may set break_live and tx_busy directly. */
`timescale 1ns/1ps
module ulc_far_end (
    input  wire logic            clk,
    output ulc_pkg::ulc_rx_evt_t rx_evt,
    output logic                 break_live,
    output logic                 tx_busy,
    output logic                 bit_tick
);
    initial begin
        rx_evt = '0;
        break_live = 1'b0;
        tx_busy = 1'b0;
    end
    always @(posedge clk) bit_tick <= (bit_tick !== 1'b1);
    task automatic send(input logic [7:0] d, input logic fe, input logic pe);
        @(posedge clk);
        rx_evt <= '{1'b1, d, fe, pe, 1'b0};
        @(posedge clk);
        rx_evt <= '0;
    endtask
endmodule

// ==== testbench/tb.sv ====
/* Self-checking bench for the line control registers over APB.
   Assumes a 20 MHz clock and a shortened millisecond count of 8 cycles. */
`timescale 1ns/1ps
module tb;
    logic                 clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0]          paddr = '0;
    logic [31:0]          pwdata = '0, prdata, rd;
    logic                 pready, pslverr, er, class_cmd = 1'b0, rx_fifo_full = 1'b0, line_break, pin_five_oe;
    logic                 break_live, tx_busy, bit_tick;
    logic                 tx_enable, rx_enable, tx_allowed, rx_accept, pin_five_o, wide_mode;
    logic                 addr_match = 1'b0, cts = 1'b0;
    logic [11:0]          pin_function;
    logic [5:0]           pin_direction, pin_irq_mask;
    ulc_pkg::ulc_flow_mode_t flow_mode;
    ulc_pkg::ulc_otp_wr_t otp_wr = '0;
    ulc_pkg::ulc_rx_evt_t rx_evt;
    int                   fail_count = 0, cmp_count = 0;
    // Index, write value, expected read-back
    logic [35:0]          rows [6] = '{{12'hc06, 12'hfff, 12'h00f}, {12'hc07, 12'habc, 12'h0bc},
        {12'hc08, 12'h3c5, 12'h0c5}, {12'hc0b, 12'h0ff, 12'h00f}, {12'h217, 12'h00f, 12'h000},
        {12'hc00, 12'hffe, 12'h002}};
    always #25 clk = ~clk;
    ulc_far_end far_inst (.clk(clk), .rx_evt(rx_evt), .break_live(break_live), .tx_busy(tx_busy),
        .bit_tick(bit_tick));
    ulc_line_ctrl #(.MS_CYCLES(8)) ulc_line_ctrl_inst (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .otp_wr(otp_wr), .class_cmd(class_cmd), .rx_evt(rx_evt),
        .rx_fifo_full(rx_fifo_full), .break_live(break_live), .addr_match(addr_match), .tx_busy(tx_busy),
        .bit_tick(bit_tick), .clear_to_send(cts), .set_ready(cts), .tx_enable(tx_enable), .rx_enable(rx_enable),
        .tx_allowed(tx_allowed), .rx_accept(rx_accept), .flow_mode(flow_mode), .wide_mode(wide_mode),
        .line_break(line_break), .pin_function(pin_function), .pin_direction(pin_direction),
        .pin_irq_mask(pin_irq_mask), .pin_five_o(pin_five_o), .pin_five_oe(pin_five_oe));
    task automatic apb(input logic w, input logic [11:0] ix, input logic [11:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= {20'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Paths off, mode written, paths back on, one settling edge
    task automatic setmode(input logic [11:0] m);
        apb(1'b1, 12'hc00, 12'h0);
        apb(1'b1, 12'hc06, m);
        apb(1'b1, 12'hc00, 12'h3);
        @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i][35:24], rows[i][23:12]);
            apb(1'b0, rows[i][35:24], 12'h0);
            chk("readback", rd, {20'h0, rows[i][11:0]});
        end
        rx_fifo_full <= 1'b1;
        far_inst.send(8'h41, 1'b1, 1'b1);
        apb(1'b0, 12'hc09, 12'h0);
        chk("err", rd, 32'h70);
        apb(1'b0, 12'hc09, 12'h0);
        chk("err clr", rd, 32'h0);
        far_inst.break_live <= 1'b1;
        apb(1'b0, 12'hc09, 12'h0);
        chk("brk", rd, 32'h88);
        far_inst.break_live <= 1'b0;
        apb(1'b0, 12'hc09, 12'h0);
        chk("brk held", rd, 32'h08);
        apb(1'b1, 12'hc0a, 12'h002);
        repeat (2) @(posedge clk);
        chk("brk on", line_break, 1);
        repeat (20) @(posedge clk);
        chk("brk off", line_break, 0);
        far_inst.tx_busy <= 1'b1;
        apb(1'b1, 12'hc0a, 12'hfff);
        repeat (3) @(posedge clk);
        chk("brk wait", line_break, 0);
        far_inst.tx_busy <= 1'b0;
        repeat (40) @(posedge clk);
        apb(1'b0, 12'hc0a, 12'h0);
        chk("hold", {rd[11:0], line_break}, {12'hfff, 1'b1});
        apb(1'b1, 12'hc0a, 12'h0);
        repeat (2) @(posedge clk);
        chk("brk stop", line_break, 0);
        otp_wr <= '{1'b1, ulc_pkg::OTP_SEL_FUNC, 12'h00b};
        @(posedge clk);
        otp_wr <= '{1'b1, ulc_pkg::OTP_SEL_DIR, 12'h02a};
        @(posedge clk);
        otp_wr <= '{1'b1, ulc_pkg::OTP_SEL_MASK, 12'h015};
        @(posedge clk);
        otp_wr <= '0;
        class_cmd <= 1'b1;
        @(posedge clk);
        class_cmd <= 1'b0;
        apb(1'b0, 12'hc0c, 12'h0);
        chk("copy", {rd[11:0], pin_five_oe}, {12'h00b, 1'b1});
        chk("copy pins", {pin_function, pin_direction, pin_irq_mask}, {12'h00b, 6'h2a, 6'h15});
        apb(1'b0, 12'h001, 12'h0);
        chk("unmapped", {rd[11:0], er}, {12'h000, 1'b1});
        chk("en", {tx_enable, rx_enable}, 2'b01);
        far_inst.tx_busy <= 1'b1;
        @(posedge clk);
        chk("hd", {rx_accept, pin_five_o}, 2'b01);
        far_inst.tx_busy <= 1'b0;
        repeat (10) @(posedge clk);
        chk("turn hold", pin_five_o, 1);
        repeat (30) @(posedge clk);
        chk("turn done", {rx_accept, pin_five_o}, 2'b10);
        setmode(12'h002);
        chk("sw mode", {flow_mode, tx_allowed}, 4'h5);
        far_inst.send(8'hc5, 1'b0, 1'b0);
        @(posedge clk);
        chk("paused", tx_allowed, 0);
        far_inst.send(8'hbc, 1'b0, 1'b0);
        @(posedge clk);
        chk("resumed", tx_allowed, 1);
        // Overrun lands in the access cycle of the clearing read
        fork
            apb(1'b0, 12'hc09, 12'h0);
            begin
                @(posedge clk);
                far_inst.send(8'h55, 1'b0, 1'b0);
            end
        join
        chk("err read", rd, 32'h40);
        apb(1'b0, 12'hc09, 12'h0);
        chk("err kept", rd, 32'h40);
        setmode(12'h004);
        chk("match off", {tx_allowed, rx_accept}, 2'b00);
        addr_match <= 1'b1;
        @(posedge clk);
        chk("match on", {tx_allowed, rx_accept}, 2'b11);
        setmode(12'h003);
        addr_match <= 1'b0;
        @(posedge clk);
        chk("match rx", {tx_allowed, rx_accept}, 2'b10);
        setmode(12'h001);
        chk("hw stop", tx_allowed, 0);
        cts <= 1'b1;
        @(posedge clk);
        chk("hw go", tx_allowed, 1);
        apb(1'b1, 12'hc00, 12'h0);
        apb(1'b1, 12'h20d, 12'h1);
        apb(1'b1, 12'hc0c, 12'h001);
        class_cmd <= 1'b1;
        @(posedge clk);
        class_cmd <= 1'b0;
        apb(1'b0, 12'hc0c, 12'h0);
        chk("custom", {rd[11:0], pin_five_oe}, {12'h001, 1'b0});
        far_inst.send(8'h00, 1'b1, 1'b0);
        apb(1'b1, 12'hd02, 12'h1);
        far_inst.send(8'h00, 1'b0, 1'b1);
        apb(1'b0, 12'hc09, 12'h0);
        chk("wide", {rd[11:0], wide_mode}, {12'h060, 1'b1});
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, 12'hc07, 12'h0);
        chk("resume rst", rd, 32'h17);
        apb(1'b0, 12'hc08, 12'h0);
        chk("pause rst", rd, 32'h19);
        report_and_stop;
    end
endmodule
